// >>> design/mom_regs.svh
`ifndef MOM_REGS_SVH
`define MOM_REGS_SVH
// Operation
// R1: Pulse monitor source code 00..07 picks frequency, current, torque, pulses, voltage, power, etc.
// R2: Every pulse monitor code except 03 gives fixed-period pulse-width output.
// R3: Pulse-width duty is scaled by an 8-bit gain 0..255; full-scale calibration forces on. The code forces the value to full scale, still scaled by the gain.
// R4: Code 03 gives pulses at ten times output frequency, at most 4 kHz. The code gives pulses at the output frequency itself, clipped to 4000 Hz.
// R5: Pulse-train ceiling follows the maximum frequency setting times ten. The code clips to the maximum frequency setting itself, without the factor ten.
// R6: Pulse-train frequency is generated digitally and ignores the pulse-width gain.
// R7: Voltage and current monitors pick sources independently, codes 00..02 and 04..07.
// R8: Each analog monitor has its own gain 0..255, defaults 180 and 80.
// R9: Each analog monitor has its own offset, 0..10.0 V and 0..20.0 mA, default zero.
// R10: Torque reads valid only under the three vector control methods.
// R11: Duty is value over full scale times gain, limited to the whole period.

// Register byte offsets
`define MOM_ADDR_W 6
`define MOM_OFS_PSEL 6'h00
`define MOM_OFS_PGAIN 6'h04
`define MOM_OFS_MAXF 6'h08
`define MOM_OFS_VSEL 6'h0C
`define MOM_OFS_ISEL 6'h10
`define MOM_OFS_VGAIN 6'h14
`define MOM_OFS_VOFS 6'h18
`define MOM_OFS_IGAIN 6'h1C
`define MOM_OFS_IOFS 6'h20
`define MOM_OFS_CTRL 6'h24
`define MOM_OFS_STAT 6'h28
`define MOM_OFS_ACODE 6'h2C

// Reset values
`define MOM_RST_PSEL 8'h00
`define MOM_RST_PGAIN 8'h80
`define MOM_RST_MAXF 16'h0FA0
`define MOM_RST_VSEL 8'h00
`define MOM_RST_ISEL 8'h00
`define MOM_RST_VGAIN 8'hB4
`define MOM_RST_IGAIN 8'h50
`define MOM_RST_VOFS 8'h00
`define MOM_RST_IOFS 8'h00

// Selector codes and scaling
`define MOM_SEL_FREQ 8'h00
`define MOM_SEL_CURR 8'h01
`define MOM_SEL_TORQ 8'h02
`define MOM_SEL_PULSE 8'h03
`define MOM_SEL_VOLT 8'h04
`define MOM_SEL_POWR 8'h05
`define MOM_SEL_THRM 8'h06
`define MOM_SEL_RAMP 8'h07
`define MOM_FS_200PCT 16'h07D0
`define MOM_FS_100PCT 16'h03E8
`define MOM_FRAC_ONE 13'h1000
`define MOM_VOFS_MAX 8'h64
`define MOM_IOFS_MAX 8'hC8
`define MOM_OFS_STEP 5'h14
`define MOM_CODE_MAX 13'h0FFF
`define MOM_DUTY_FULL 9'h100
`define MOM_CM_SLV 3'h3
`define MOM_CM_SLV0 3'h4
`define MOM_CM_FB 3'h5

// Timing
`define MOM_CLK_HZ 40000000
`define MOM_PULSE_MAX_HZ 16'h0FA0
`define MOM_PWM_STEP_DIV 4'hF
`endif

// >>> design/mom_pkg.sv
package mom_pkg;
    typedef enum logic {MOM_MODE_PWM, MOM_MODE_PULSE} mom_mode_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic arready;
        logic aw_got;
        logic [5:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] psel;
        logic [7:0] pgain;
        logic [15:0] maxf;
        logic [7:0] vsel;
        logic [7:0] isel;
        logic [7:0] vgain;
        logic [7:0] vofs;
        logic [7:0] igain;
        logic [7:0] iofs;
        logic cal;
        mom_mode_t mode;
        logic [3:0] div;
        logic [7:0] pwm_cnt;
        logic [8:0] duty;
        logic pulse_out;
        logic [11:0] vcode;
        logic [11:0] icode;
    } mom_state_t;

    typedef struct packed {
        logic [24:0] acc;
        logic level;
    } mom_pt_state_t;
endpackage

// >>> design/mom_pulse_train.sv
`timescale 1ns/100ps
`include "mom_regs.svh"
module mom_pulse_train #(
    parameter int CLK_HZ = `MOM_CLK_HZ
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic [15:0] freq_hz,
    output logic level
);
    localparam logic [24:0] HALF = 25'(CLK_HZ / 2);

    mom_pkg::mom_pt_state_t s_reg;
    mom_pkg::mom_pt_state_t s_next;

    // ----------------------------------------
    // Phase accumulator, toggles twice per period
    // ----------------------------------------
    always_comb begin
        s_next = s_reg;
        if (!enable) begin
            s_next.acc = 25'h0000000;
            s_next.level = 1'b0;
        end else if (s_reg.acc + 25'(freq_hz) >= HALF) begin // see R6
            s_next.acc = s_reg.acc + 25'(freq_hz) - HALF;
            s_next.level = !s_reg.level;
        end else begin
            s_next.acc = s_reg.acc + 25'(freq_hz);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign level = s_reg.level;
endmodule

// >>> design/mom_monitor_top.sv
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
`include "mom_regs.svh"
module mom_monitor_top #(
    parameter int CLK_HZ = `MOM_CLK_HZ
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] out_freq,
    input wire logic [15:0] out_current,
    input wire logic [15:0] out_torque,
    input wire logic [15:0] out_voltage,
    input wire logic [15:0] in_power,
    input wire logic [15:0] thermal_load,
    input wire logic [15:0] ramp_freq,
    input wire logic [2:0] control_method,
    output logic pulse_monitor_out,
    output logic [11:0] voltage_monitor_out,
    output logic [11:0] current_monitor_out
);
    mom_pkg::mom_state_t s_reg;
    mom_pkg::mom_state_t s_next;
    logic pt_level;
    logic [15:0] pt_freq;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Returns {full_scale, value} for a source code; zero scale means no source
    function automatic logic [31:0] pick(input logic [7:0] code, input logic analog);
        logic [31:0] r;
        r = 32'h00000000;
        if (code == `MOM_SEL_FREQ) begin // see R1
            r = {s_reg.maxf, out_freq};
        end else if (code == `MOM_SEL_CURR) begin
            r = {`MOM_FS_200PCT, out_current};
        end else if (code == `MOM_SEL_TORQ) begin
            if (control_method == `MOM_CM_SLV || control_method == `MOM_CM_SLV0 ||
                control_method == `MOM_CM_FB) begin // see R10
                r = {`MOM_FS_200PCT, out_torque};
            end
        end else if (code == `MOM_SEL_PULSE) begin
            if (!analog) begin
                r = {s_reg.maxf, out_freq};
            end
        end else if (code == `MOM_SEL_VOLT) begin
            r = {`MOM_FS_100PCT, out_voltage};
        end else if (code == `MOM_SEL_POWR) begin
            r = {`MOM_FS_200PCT, in_power};
        end else if (code == `MOM_SEL_THRM) begin
            r = {`MOM_FS_100PCT, thermal_load};
        end else if (code == `MOM_SEL_RAMP) begin
            r = {s_reg.maxf, ramp_freq};
        end
        return r;
    endfunction

    // Value over full scale as a fraction of 4096, saturated
    function automatic logic [12:0] frac(input logic [31:0] fv);
        logic [28:0] q;
        q = 29'h00000000;
        if (fv[31:16] != 16'h0000) begin
            q = {1'b0, fv[15:0], 12'h000} / 29'(fv[31:16]);
        end
        if (q > 29'(`MOM_FRAC_ONE)) begin
            q = 29'(`MOM_FRAC_ONE);
        end
        return q[12:0];
    endfunction

    // Analog code = fraction * gain / 256 + offset step, saturated to 12 bits
    function automatic logic [11:0] acode(input logic [12:0] f, input logic [7:0] g,
                                          input logic [7:0] o);
        logic [21:0] t;
        t = 22'(({f, 8'h00} / 21'h00100) * 21'(g) / 21'h00100) + 22'(o) * 22'(`MOM_OFS_STEP);
        if (t > 22'(`MOM_CODE_MAX)) begin
            t = 22'(`MOM_CODE_MAX);
        end
        return t[11:0];
    endfunction

    // Byte-lane merge of a write into an old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] clip8(input logic [7:0] v, input logic [7:0] mx);
        return (v > mx) ? mx : v;
    endfunction

    // ----------------------------------------
    // Pulse-train generator
    // ----------------------------------------
    always_comb begin
        pt_freq = out_freq;
        if (pt_freq > s_reg.maxf) begin // see R5
            pt_freq = s_reg.maxf;
        end
        if (pt_freq > `MOM_PULSE_MAX_HZ) begin // see R4
            pt_freq = `MOM_PULSE_MAX_HZ;
        end
    end

    mom_pulse_train #(
        .CLK_HZ(CLK_HZ)
    ) u_pt (
        .sys_clk(sys_clk),
        .rst(rst),
        .enable(s_reg.mode == mom_pkg::MOM_MODE_PULSE),
        .freq_hz(pt_freq),
        .level(pt_level)
    );

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        logic [31:0] wv;
        logic [5:0] a;
        logic [12:0] pf;
        logic [20:0] pd;
        wv = 32'h00000000;
        a = 6'h00;
        pf = 13'h0000;
        pd = 21'h000000;
        s_next = s_reg;

        // Write channel
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end
        if (s_axi_awvalid && s_reg.awready) begin
            s_next.aw_got = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_reg.wready) begin
            s_next.w_got = 1'b1;
            s_next.w_data = s_axi_wdata;
            s_next.w_strb = s_axi_wstrb;
        end
        if (s_next.aw_got && s_next.w_got && !s_next.bvalid) begin
            a = {s_next.aw_addr[5:2], 2'b00};
            s_next.bvalid = 1'b1;
            s_next.bresp = 2'b00;
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            if (a == `MOM_OFS_PSEL) begin
                wv = merge({24'h000000, s_reg.psel}, s_next.w_data, s_next.w_strb);
                s_next.psel = wv[7:0];
            end else if (a == `MOM_OFS_PGAIN) begin
                wv = merge({24'h000000, s_reg.pgain}, s_next.w_data, s_next.w_strb);
                s_next.pgain = wv[7:0];
            end else if (a == `MOM_OFS_MAXF) begin
                wv = merge({16'h0000, s_reg.maxf}, s_next.w_data, s_next.w_strb);
                s_next.maxf = wv[15:0];
            end else if (a == `MOM_OFS_VSEL) begin
                wv = merge({24'h000000, s_reg.vsel}, s_next.w_data, s_next.w_strb);
                s_next.vsel = wv[7:0];
            end else if (a == `MOM_OFS_ISEL) begin
                wv = merge({24'h000000, s_reg.isel}, s_next.w_data, s_next.w_strb);
                s_next.isel = wv[7:0];
            end else if (a == `MOM_OFS_VGAIN) begin
                wv = merge({24'h000000, s_reg.vgain}, s_next.w_data, s_next.w_strb);
                s_next.vgain = wv[7:0];
            end else if (a == `MOM_OFS_VOFS) begin
                wv = merge({24'h000000, s_reg.vofs}, s_next.w_data, s_next.w_strb);
                s_next.vofs = clip8(wv[7:0], `MOM_VOFS_MAX); // see R9
            end else if (a == `MOM_OFS_IGAIN) begin
                wv = merge({24'h000000, s_reg.igain}, s_next.w_data, s_next.w_strb);
                s_next.igain = wv[7:0];
            end else if (a == `MOM_OFS_IOFS) begin
                wv = merge({24'h000000, s_reg.iofs}, s_next.w_data, s_next.w_strb);
                s_next.iofs = clip8(wv[7:0], `MOM_IOFS_MAX); // see R9
            end else if (a == `MOM_OFS_CTRL) begin
                wv = merge({31'h00000000, s_reg.cal}, s_next.w_data, s_next.w_strb);
                s_next.cal = wv[0];
            end else if (a == `MOM_OFS_STAT || a == `MOM_OFS_ACODE) begin
                s_next.bresp = 2'b00;
            end else begin
                s_next.bresp = 2'b10;
            end
        end

        // Read channel
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_reg.arready) begin
            a = {s_axi_araddr[5:2], 2'b00};
            s_next.rvalid = 1'b1;
            s_next.rresp = 2'b00;
            s_next.rdata = 32'h00000000;
            if (a == `MOM_OFS_PSEL) begin
                s_next.rdata = {24'h000000, s_reg.psel};
            end else if (a == `MOM_OFS_PGAIN) begin
                s_next.rdata = {24'h000000, s_reg.pgain};
            end else if (a == `MOM_OFS_MAXF) begin
                s_next.rdata = {16'h0000, s_reg.maxf};
            end else if (a == `MOM_OFS_VSEL) begin
                s_next.rdata = {24'h000000, s_reg.vsel};
            end else if (a == `MOM_OFS_ISEL) begin
                s_next.rdata = {24'h000000, s_reg.isel};
            end else if (a == `MOM_OFS_VGAIN) begin
                s_next.rdata = {24'h000000, s_reg.vgain};
            end else if (a == `MOM_OFS_VOFS) begin
                s_next.rdata = {24'h000000, s_reg.vofs};
            end else if (a == `MOM_OFS_IGAIN) begin
                s_next.rdata = {24'h000000, s_reg.igain};
            end else if (a == `MOM_OFS_IOFS) begin
                s_next.rdata = {24'h000000, s_reg.iofs};
            end else if (a == `MOM_OFS_CTRL) begin
                s_next.rdata = {31'h00000000, s_reg.cal};
            end else if (a == `MOM_OFS_STAT) begin
                s_next.rdata = {20'h00000, s_reg.pulse_out, s_reg.mode == mom_pkg::MOM_MODE_PULSE,
                                1'b0, s_reg.duty};
            end else if (a == `MOM_OFS_ACODE) begin
                s_next.rdata = {4'h0, s_reg.icode, 4'h0, s_reg.vcode};
            end else begin
                s_next.rresp = 2'b10;
            end
        end

        s_next.awready = !s_next.aw_got && !s_next.bvalid;
        s_next.wready = !s_next.w_got && !s_next.bvalid;
        s_next.arready = !s_next.rvalid;

        // Digital monitor
        s_next.mode = (s_reg.psel == `MOM_SEL_PULSE) ? mom_pkg::MOM_MODE_PULSE
                                                     : mom_pkg::MOM_MODE_PWM; // see R2
        pf = s_reg.cal ? `MOM_FRAC_ONE : frac(pick(s_reg.psel, 1'b0)); // see R3
        pd = 21'((29'({pf, 8'h00}) * 29'(s_reg.pgain)) >> 19); // see R11
        if (s_reg.div == `MOM_PWM_STEP_DIV) begin
            s_next.div = 4'h0;
            s_next.pwm_cnt = s_reg.pwm_cnt + 8'h01;
            if (s_reg.pwm_cnt == 8'hFF) begin
                s_next.duty = (pd > 21'(`MOM_DUTY_FULL)) ? `MOM_DUTY_FULL : pd[8:0]; // see R11
            end
        end else begin
            s_next.div = s_reg.div + 4'h1;
        end
        if (s_reg.mode == mom_pkg::MOM_MODE_PULSE) begin
            s_next.pulse_out = pt_level; // see R4
        end else begin
            s_next.pulse_out = {1'b0, s_reg.pwm_cnt} < s_reg.duty; // see R2
        end

        // Analog monitors, each with its own source, gain and offset
        s_next.vcode = acode(frac(pick(s_reg.vsel, 1'b1)), s_reg.vgain, s_reg.vofs); // see R7
        s_next.icode = acode(frac(pick(s_reg.isel, 1'b1)), s_reg.igain, s_reg.iofs); // see R8
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.psel <= `MOM_RST_PSEL;
            s_reg.pgain <= `MOM_RST_PGAIN;
            s_reg.maxf <= `MOM_RST_MAXF;
            s_reg.vsel <= `MOM_RST_VSEL;
            s_reg.isel <= `MOM_RST_ISEL;
            s_reg.vgain <= `MOM_RST_VGAIN; // see R8
            s_reg.igain <= `MOM_RST_IGAIN;
            s_reg.vofs <= `MOM_RST_VOFS; // see R9
            s_reg.iofs <= `MOM_RST_IOFS;
        end else begin
            s_reg <= s_next;
        end
    end

    assign s_axi_awready = s_reg.awready;
    assign s_axi_wready = s_reg.wready;
    assign s_axi_arready = s_reg.arready;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign pulse_monitor_out = s_reg.pulse_out;
    assign voltage_monitor_out = s_reg.vcode;
    assign current_monitor_out = s_reg.icode;
endmodule

// >>> bench/mom_monitor_sva.sv
`timescale 1ns/100ps
module mom_monitor_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pulse_monitor_out,
    input wire logic [11:0] voltage_monitor_out
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // ----------------------------------------
    // Register bus handshakes
    // ----------------------------------------
    chk_b_follows: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write response missing");
    chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    chk_aw_returns: assert property (s_axi_bvalid && s_axi_bready
        |=> ##1 s_axi_awready && s_axi_wready) else $error("write ready not restored");
    chk_r_follows: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");
    chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 6'h30
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read answered");
    chk_reset_quiet: assert property (disable iff (1'b0) rst |=> !s_axi_bvalid && !s_axi_rvalid
        && !s_axi_awready && !pulse_monitor_out && voltage_monitor_out == 12'h000)
        else $error("outputs active after reset");
endmodule

bind mom_monitor_top mom_monitor_chk u_chk (
    .sys_clk(sys_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pulse_monitor_out(pulse_monitor_out), .voltage_monitor_out(voltage_monitor_out)
);

// >>> bench/mom_meter.sv
`timescale 1ns/100ps
module mom_meter (
    input wire logic sys_clk,
    input wire logic clr,
    input wire logic pin,
    output logic [31:0] high_cnt,
    output logic [31:0] rise_cnt
);
    logic pin_reg;
    // Averages on-time like a coil and counts pulses like a counter input
    always_ff @(posedge sys_clk) begin
        pin_reg <= pin;
        if (clr) begin
            high_cnt <= 32'h0;
            rise_cnt <= 32'h0;
        end else begin
            high_cnt <= high_cnt + 32'(pin);
            rise_cnt <= rise_cnt + 32'(pin && !pin_reg);
        end
    end
endmodule

// >>> bench/testbench.sv
`timescale 1ns/100ps
module testbench;
    localparam int CLK_HZ = 400000;
    localparam int WIN = 10000;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic clr = 1'b0;
    logic [5:0] awaddr = 6'h00;
    logic [5:0] araddr = 6'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [2:0] cm = 3'h0;
    logic awready, wready, bvalid, arready, rvalid, pin;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, high_cnt, rise_cnt;
    logic [11:0] vout, iout;
    logic [15:0] val [8];
    logic [31:0] seed = 32'hCFC4;
    logic [15:0] maxf_m = 16'h0FA0;
    logic [5:0] dflt_a [6] = '{6'h04, 6'h08, 6'h14, 6'h18, 6'h1C, 6'h20};
    logic [31:0] dflt_v [6] = '{32'h80, 32'hFA0, 32'hB4, 32'h0, 32'h50, 32'h0};
    logic [15:0] pt_f [3] = '{16'h0258, 16'h1388, 16'h03E8};
    logic [15:0] pt_m [3] = '{16'h0FA0, 16'h1770, 16'h0258};
    int err_total = 0;
    int tests_run = 0;

    always #12.5 sys_clk = ~sys_clk;

    mom_monitor_top #(.CLK_HZ(CLK_HZ)) dut (
        .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .out_freq(val[0]), .out_current(val[1]), .out_torque(val[2]), .out_voltage(val[4]),
        .in_power(val[5]), .thermal_load(val[6]), .ramp_freq(val[7]), .control_method(cm),
        .pulse_monitor_out(pin), .voltage_monitor_out(vout), .current_monitor_out(iout)
    );

    mom_meter u_meter (.sys_clk(sys_clk), .clr(clr), .pin(pin), .high_cnt(high_cnt),
        .rise_cnt(rise_cnt));

    // ----------------------------------------
    // Reporting and expectations
    // ----------------------------------------
    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic int unsigned frac_of(input logic [2:0] c);
        int unsigned fs;
        int unsigned v;
        fs = (c == 3'h0 || c == 3'h7) ? maxf_m : (c == 3'h4 || c == 3'h6) ? 1000 : 2000;
        v = (c == 3'h2 && (cm < 3'h3 || cm > 3'h5)) ? 0 : val[c];
        if (fs == 0) return 0;
        v = v * 4096 / fs;
        return (v > 4096) ? 4096 : v;
    endfunction

    function automatic int unsigned acode(input logic [2:0] c, input logic [7:0] g,
        input logic [7:0] o);
        int unsigned s;
        s = (c == 3'h3) ? 0 : frac_of(c) * g / 256 + o * 20;
        return (s > 4095) ? 4095 : s;
    endfunction

    function automatic int unsigned duty_of(input logic cal, input logic [2:0] c,
        input logic [7:0] g);
        int unsigned s;
        s = ((cal ? 4096 : frac_of(c)) * 256 * g) >> 19;
        return (s > 256) ? 256 : s;
    endfunction

    // ----------------------------------------
    // Bus and meter tasks
    // ----------------------------------------
    task automatic axi_wr(input logic [5:0] a, input logic [31:0] v, output logic [1:0] r);
        int n;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
        end
        bready <= 1'b0;
        r = bresp;
        if (n == 64) begin
            err_total++;
            final_report();
        end
    endtask

    task automatic axi_rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] r);
        int n;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
        end
        rready <= 1'b0;
        v = rdata;
        r = rresp;
        if (n == 64) begin
            err_total++;
            final_report();
        end
    endtask

    task automatic measure(input int w);
        @(posedge sys_clk);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        repeat (w) @(posedge sys_clk);
        #1;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [1:0] r;
        logic [31:0] d;
        logic [7:0] g, vo, io;
        logic [2:0] c;
        int unsigned e;
        for (int k = 0; k < 8; k++) val[k] = 16'h0;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        foreach (dflt_a[i]) begin
            axi_rd(dflt_a[i], d, r);
            check("reset value", dflt_v[i], d);
        end
        axi_wr(6'h30, 32'hFF, r);
        check("unmapped bresp", 32'h2, 32'(r));
        axi_rd(6'h3C, d, r);
        check("unmapped rresp", 32'h2, 32'(r));
        axi_wr(6'h28, 32'h0, r);
        check("read-only bresp", 32'h0, 32'(r));
        for (int i = 0; i < 8; i++) begin
            cm <= (i == 2) ? 3'h1 : (i == 5) ? 3'h4 : 3'(rnd());
            for (int k = 0; k < 8; k++) val[k] <= 16'(rnd() % 3000);
            g = (i == 0) ? 8'hFF : 8'(rnd());
            vo = (i == 3) ? 8'h00 : (i == 1) ? 8'h64 : 8'(rnd() % 101);
            io = (i == 4) ? 8'h00 : (i == 1) ? 8'hC8 : 8'(rnd() % 201);
            axi_wr(6'h0C, 32'(i), r);
            axi_wr(6'h10, 32'(7 - i), r);
            axi_wr(6'h14, 32'(g), r);
            axi_wr(6'h1C, 32'(~g), r);
            axi_wr(6'h18, 32'(vo), r);
            axi_wr(6'h20, 32'(io), r);
            axi_rd(6'h14, d, r);
            check("voltage gain", 32'(g), d);
            repeat (4) @(posedge sys_clk);
            check("voltage code", acode(3'(i), g, vo), 32'(vout));
            check("current code", acode(3'(7 - i), ~g, io), 32'(iout));
        end
        for (int i = 0; i < 3; i++) begin
            c = (i == 2) ? 3'h6 : 3'h1;
            g = (i == 0) ? 8'h64 : (i == 1) ? 8'h80 : 8'hFF;
            axi_wr(6'h24, 32'(i < 2), r);
            axi_wr(6'h00, 32'(c), r);
            axi_wr(6'h04, 32'(g), r);
            e = duty_of(i < 2, c, g);
            // Duty is only taken at the 4096-clock period wrap
            repeat (4200) @(posedge sys_clk);
            axi_rd(6'h28, d, r);
            check("duty", e, {23'h0, d[8:0]});
            check("pwm mode", 32'h0, 32'(d[10]));
            measure(8192);
            check("on time", e * 32, high_cnt);
        end
        axi_wr(6'h24, 32'h0, r);
        axi_wr(6'h00, 32'h3, r);
        for (int i = 0; i < 3; i++) begin
            val[0] <= pt_f[i];
            maxf_m = pt_m[i];
            axi_wr(6'h08, 32'(maxf_m), r);
            axi_wr(6'h04, rnd(), r);
            repeat (200) @(posedge sys_clk);
            axi_rd(6'h28, d, r);
            check("train mode", 32'h1, 32'(d[10]));
            measure(WIN);
            e = (pt_f[i] < pt_m[i]) ? pt_f[i] : pt_m[i];
            e = ((e > 4000) ? 4000 : e) * WIN / CLK_HZ;
            check("train edges", e, (rise_cnt + 1 - e <= 2) ? e : rise_cnt);
        end
        final_report();
    end
endmodule
